// File: lrht_pkg.sv
package lrht_pkg;

    // ----------------------------------------
    // clock and hang timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int NS_PER_MS      = 1000000;
    localparam int HANG_LONG_MS   = 500;
    localparam int HANG_SHORT_MS  = 20;
    localparam int HANG_LONG_CYC  = HANG_LONG_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int HANG_SHORT_CYC = HANG_SHORT_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int HANG_CNT_W     = 32;

    // ----------------------------------------
    // mode select and packet layout
    // ----------------------------------------
    localparam int SEL_NET_BIT  = 0;
    localparam int SEL_FAST_BIT = 1;
    localparam int SEL_RX_BIT   = 2;
    localparam int OUT_A_BIT    = 4;
    localparam int OUT_B_BIT    = 5;
    localparam int OUT_C_BIT    = 6;
    localparam int BYTE0_HI     = 39;
    localparam int BYTE0_LO     = 32;
    localparam logic [2:0] PKT_SHORT_LEN = 3'h1;
    localparam logic [2:0] PKT_FULL_LEN  = 3'h5;
    localparam int ID_SLOTS  = 4;
    localparam int ID_IDX_W  = 2;
    localparam int ID_CNT_W  = 3;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_LASTID = 8'h08;
    localparam int CTRL_LEARN_BIT  = 0;
    localparam int CTRL_FORGET_BIT = 1;
    localparam int CTRL_OFF_BIT    = 2;
    localparam int STAT_OUT_LO     = 0;
    localparam int STAT_MODE_LO    = 4;
    localparam int STAT_LEARN_BIT  = 7;
    localparam int STAT_CNT_LO     = 8;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic {LRHT_WATCH, LRHT_LEARN} lrht_learn_type;

endpackage

// File: lrht_id_if.sv
`timescale 1ns/1ps
// learned sender table port group
interface lrht_id_if;
    logic [31:0] probeId;
    logic        hit;
    logic        storeEn;
    logic [31:0] storeId;
    logic        forget;
    logic [2:0]  count;
    modport store (input probeId, storeEn, storeId, forget, output hit, count);
    modport user  (output probeId, storeEn, storeId, forget, input hit, count);
endinterface

// File: lrht_id_table.sv
`timescale 1ns/1ps
module lrht_id_table
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // table access
    lrht_id_if.store  idBus
);

    logic [31:0]                  slot_q [lrht_pkg::ID_SLOTS];
    logic [lrht_pkg::ID_SLOTS-1:0] used_q;
    logic [lrht_pkg::ID_IDX_W-1:0] wrPtr_q;
    logic [lrht_pkg::ID_CNT_W-1:0] count_q;
    logic [31:0]                   lastStore_q;
    logic                          storedHit;

    // --------------------------------------------------
    // lookup
    // --------------------------------------------------
    function automatic logic idMatch(input logic [31:0] id);
        logic m;
        m = 1'b0;
        for (int i = 0; i < lrht_pkg::ID_SLOTS; i++)
        begin
            if (used_q[i] && slot_q[i] == id)
                m = 1'b1;
        end
        return m;
    endfunction

    assign idBus.hit   = idMatch(idBus.probeId);
    assign idBus.count = count_q;

    // storage: oldest slot is overwritten once full
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || idBus.forget)
        begin
            used_q  <= '0;
            wrPtr_q <= '0;
            count_q <= '0;
        end
        else if (idBus.storeEn && !idMatch(idBus.storeId))
        begin
            slot_q[wrPtr_q]  <= idBus.storeId;
            used_q[wrPtr_q]  <= 1'b1;
            wrPtr_q          <= wrPtr_q + 1'b1;
            if (count_q != lrht_pkg::ID_CNT_W'(lrht_pkg::ID_SLOTS))
                count_q <= count_q + 1'b1;
        end
    end

    // last offered id, kept so the check sees it whatever the probe shows
    always_ff @(posedge core_clk)
    begin
        lastStore_q <= idBus.storeId;
    end

    assign storedHit = idMatch(lastStore_q);

    // a stored sender is found on the next cycle
    property p_store_hit;
        @(posedge core_clk) disable iff (sys_rst)
        idBus.storeEn && !idBus.forget |=> storedHit;
    endproperty
    a_store_hit: assert property (p_store_hit) else $error("learned id not found");

endmodule

// File: lrht_receiver.sv
`timescale 1ns/1ps
// Overview of operation
// - In receiver modes the block stays receiving and never enables the transmitter.
// - Switch outputs follow the three state bits of each accepted packet.
// - Select1 low: outputs hold 500 ms after last packet, then all off.
// - Select1 high: hang time is 20 ms instead of 500 ms.
// - All three selects high: network receiver with 20 ms hang time.
// - Network modes: learn pin pulse enters learn, pin also shows learn status.
// - Each switch output is driven high when its received bit is one.
// - Byte one bits 6, 5, 4 carry output c, b, a.
// - Accepted five-byte packets are forwarded whole, identifier from the header.
// - Network mode forwards nothing for unlearned senders.
// - A single all-zero byte turns all outputs off at once.
// - Non-network receiver accepts every packet whatever its sender.
// - Network receiver accepts only packets from learned senders.
// - Selects 0,0,1 pick plain 500 ms receiver; select0 high together with select2 high picks network.
module lrht_receiver
#(
    parameter int HANG_LONG_CYC  = lrht_pkg::HANG_LONG_CYC,
    parameter int HANG_SHORT_CYC = lrht_pkg::HANG_SHORT_CYC
)
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // mode straps
    input  wire logic [2:0]  modeSel,
    // received radio packets
    input  wire logic        pktValid,
    input  wire logic [2:0]  pktLen,
    input  wire logic [39:0] pktData,
    input  wire logic [31:0] pktHdrId,
    // switch outputs and radio control
    output logic             switchOutputA,
    output logic             switchOutputB,
    output logic             switchOutputC,
    output logic             radioTxEn,
    // learn / status pin
    input  wire logic        learnIn,
    output logic             learnOut,
    output logic             learnOe,
    // forwarded packets
    output logic             fwdValid,
    output logic [39:0]      fwdData,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // --------------------------------------------------
    // declarations
    // --------------------------------------------------
    lrht_id_if idBus ();

    logic [2:0]                      mode_q;
    logic                            modeTaken_q;
    logic [2:0]                      outs_q;
    logic [lrht_pkg::HANG_CNT_W-1:0] hangCnt_q;
    lrht_pkg::lrht_learn_type        learn_q;
    logic                            learnInPrev_q;
    logic                            fwdValid_q;
    logic [39:0]                     fwdData_q;
    logic [31:0]                     lastId_q;
    logic [7:0]                      awAddr_q;
    logic                            awHave_q;
    logic [31:0]                     wData_q;
    logic [3:0]                      wStrb_q;
    logic                            wHave_q;
    logic                            bValid_q;
    logic [1:0]                      bResp_q;
    logic                            rValid_q;
    logic [31:0]                     rData_q;
    logic [1:0]                      rResp_q;

    logic                            rxMode;
    logic                            netMode;
    logic                            fastHang;
    logic                            accept;
    logic                            zeroPkt;
    logic [2:0]                      newOuts;
    logic [lrht_pkg::HANG_CNT_W-1:0] hangLimit;
    logic                            hangExpire;
    logic                            learnRise;
    logic                            wrFire;
    logic                            ctrlWr;
    logic                            swLearn;
    logic                            swForget;
    logic                            swOff;

    // address decode shared by both bus paths
    function automatic logic addrMapped(input logic [7:0] a);
        return a == lrht_pkg::ADDR_CTRL || a == lrht_pkg::ADDR_STATUS ||
               a == lrht_pkg::ADDR_LASTID;
    endfunction

    // --------------------------------------------------
    // mode capture
    // --------------------------------------------------
    // straps are caught on the first edge after release, never during reset
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            mode_q      <= 3'h0;
            modeTaken_q <= 1'b0;
        end
        else if (!modeTaken_q)
        begin
            mode_q      <= modeSel;
            modeTaken_q <= 1'b1;
        end
    end

    // selector bits decode the receiver variants
    assign rxMode   = modeTaken_q && mode_q[lrht_pkg::SEL_RX_BIT];
    assign netMode  = rxMode && mode_q[lrht_pkg::SEL_NET_BIT];
    assign fastHang = mode_q[lrht_pkg::SEL_FAST_BIT];

    // receive-only block: the transmitter is never keyed
    assign radioTxEn = 1'b0;

    // --------------------------------------------------
    // packet acceptance and decode
    // --------------------------------------------------
    assign idBus.probeId = pktHdrId;
    assign accept  = pktValid && rxMode && (!netMode || idBus.hit);
    assign zeroPkt = pktLen == lrht_pkg::PKT_SHORT_LEN &&
                     pktData[lrht_pkg::BYTE0_HI:lrht_pkg::BYTE0_LO] == 8'h00;
    assign newOuts = {pktData[lrht_pkg::OUT_C_BIT + lrht_pkg::BYTE0_LO],
                      pktData[lrht_pkg::OUT_B_BIT + lrht_pkg::BYTE0_LO],
                      pktData[lrht_pkg::OUT_A_BIT + lrht_pkg::BYTE0_LO]};

    // --------------------------------------------------
    // hang timer
    // --------------------------------------------------
    assign hangLimit  = fastHang ? lrht_pkg::HANG_CNT_W'(HANG_SHORT_CYC)
                                 : lrht_pkg::HANG_CNT_W'(HANG_LONG_CYC);
    assign hangExpire = outs_q != 3'h0 && hangCnt_q == hangLimit - 1'b1;

    // counter only runs while something is held high
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            hangCnt_q <= '0;
        else if (accept)
            hangCnt_q <= '0;
        else if (outs_q != 3'h0 && !hangExpire)
            hangCnt_q <= hangCnt_q + 1'b1;
        else
            hangCnt_q <= '0;
    end

    // --------------------------------------------------
    // switch outputs
    // --------------------------------------------------
    // a fresh packet outranks expiry in the same cycle, so no false drop
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || !rxMode)
            outs_q <= 3'h0;
        else if (accept && zeroPkt)
            outs_q <= 3'h0;
        else if (accept)
            outs_q <= newOuts;
        else if (hangExpire || swOff)
            outs_q <= 3'h0;
    end

    assign switchOutputA = outs_q[0];
    assign switchOutputB = outs_q[1];
    assign switchOutputC = outs_q[2];

    // --------------------------------------------------
    // learn control and status pin
    // --------------------------------------------------
    // pin is only read while we are not driving it
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            learnInPrev_q <= 1'b0;
        else
            learnInPrev_q <= learnIn && !learnOe;
    end

    assign learnRise = learnIn && !learnOe && !learnInPrev_q;

    // entry beats exit when both land in one cycle
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || !netMode)
            learn_q <= lrht_pkg::LRHT_WATCH;
        else
        begin
            case (learn_q)
                lrht_pkg::LRHT_WATCH:
                    if (learnRise || swLearn)
                        learn_q <= lrht_pkg::LRHT_LEARN;
                lrht_pkg::LRHT_LEARN:
                    if (pktValid && !learnRise && !swLearn)
                        learn_q <= lrht_pkg::LRHT_WATCH;
                default:
                    learn_q <= lrht_pkg::LRHT_WATCH;
            endcase
        end
    end

    // learning takes the header identifier, never one from the payload
    assign idBus.storeEn = learn_q == lrht_pkg::LRHT_LEARN && pktValid;
    assign idBus.storeId = pktHdrId;
    assign idBus.forget  = swForget;
    assign learnOut      = learn_q == lrht_pkg::LRHT_LEARN;
    assign learnOe       = learn_q == lrht_pkg::LRHT_LEARN;

    lrht_id_table u_table
    (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .idBus    (idBus)
    );

    // --------------------------------------------------
    // packet forwarding
    // --------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            fwdValid_q <= 1'b0;
            fwdData_q  <= '0;
            lastId_q   <= '0;
        end
        else
        begin
            fwdValid_q <= accept && pktLen == lrht_pkg::PKT_FULL_LEN;
            if (accept)
            begin
                fwdData_q <= {pktData[lrht_pkg::BYTE0_HI:lrht_pkg::BYTE0_LO], pktHdrId};
                lastId_q  <= pktHdrId;
            end
        end
    end

    assign fwdValid = fwdValid_q;
    assign fwdData  = fwdData_q;

    // --------------------------------------------------
    // axi4-lite write path
    // --------------------------------------------------
    assign s_axi_awready = !awHave_q && !bValid_q;
    assign s_axi_wready  = !wHave_q && !bValid_q;
    assign wrFire        = awHave_q && wHave_q;
    assign ctrlWr        = wrFire && awAddr_q == lrht_pkg::ADDR_CTRL && wStrb_q[0];
    assign swLearn       = ctrlWr && wData_q[lrht_pkg::CTRL_LEARN_BIT];
    assign swForget      = ctrlWr && wData_q[lrht_pkg::CTRL_FORGET_BIT];
    assign swOff         = ctrlWr && wData_q[lrht_pkg::CTRL_OFF_BIT];

    // address and data are latched independently, in either order
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            awHave_q <= 1'b0;
            wHave_q  <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q  <= '0;
            wStrb_q  <= 4'h0;
        end
        else if (wrFire)
        begin
            awHave_q <= 1'b0;
            wHave_q  <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHave_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHave_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
        end
    end

    // write response held until the master takes it
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            bValid_q <= 1'b0;
            bResp_q  <= lrht_pkg::RESP_OKAY;
        end
        else if (wrFire)
        begin
            bValid_q <= 1'b1;
            bResp_q  <= addrMapped(awAddr_q) ? lrht_pkg::RESP_OKAY : lrht_pkg::RESP_DECERR;
        end
        else if (s_axi_bready)
            bValid_q <= 1'b0;
    end

    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp  = bResp_q;

    // --------------------------------------------------
    // axi4-lite read path
    // --------------------------------------------------
    assign s_axi_arready = !rValid_q;

    // status shows live outputs, mode, learn state and table fill
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            rValid_q <= 1'b0;
            rData_q  <= '0;
            rResp_q  <= lrht_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rValid_q <= 1'b1;
            rResp_q  <= addrMapped(s_axi_araddr) ? lrht_pkg::RESP_OKAY : lrht_pkg::RESP_DECERR;
            rData_q  <= '0;
            if (s_axi_araddr == lrht_pkg::ADDR_STATUS)
            begin
                rData_q[lrht_pkg::STAT_OUT_LO +: 3]  <= outs_q;
                rData_q[lrht_pkg::STAT_MODE_LO +: 3] <= mode_q;
                rData_q[lrht_pkg::STAT_LEARN_BIT]    <= learnOut;
                rData_q[lrht_pkg::STAT_CNT_LO +: 3]  <= idBus.count;
            end
            else if (s_axi_araddr == lrht_pkg::ADDR_LASTID)
                rData_q <= lastId_q;
        end
        else if (s_axi_rready)
            rValid_q <= 1'b0;
    end

    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata  = rData_q;
    assign s_axi_rresp  = rResp_q;

    // --------------------------------------------------
    // checks
    // --------------------------------------------------
    sequence s_quiet_hold;
        !accept && outs_q != 3'h0 && hangCnt_q == hangLimit - 1'b1;
    endsequence

    property p_no_tx;
        @(posedge core_clk) disable iff (sys_rst) rxMode |-> !radioTxEn;
    endproperty
    a_no_tx: assert property (p_no_tx) else $error("transmitter keyed");

    property p_follow;
        @(posedge core_clk) disable iff (sys_rst)
        accept && !zeroPkt |=> outs_q == $past(newOuts);
    endproperty
    a_follow: assert property (p_follow) else $error("outputs differ from packet");

    property p_zero_off;
        @(posedge core_clk) disable iff (sys_rst) accept && zeroPkt |=> outs_q == 3'h0;
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("zero byte left output on");

    property p_hang_long;
        @(posedge core_clk) disable iff (sys_rst)
        (!fastHang and s_quiet_hold) |=> outs_q == 3'h0 && hangCnt_q == '0;
    endproperty
    a_hang_long: assert property (p_hang_long) else $error("long hang not ended");

    property p_hang_short;
        @(posedge core_clk) disable iff (sys_rst)
        fastHang && outs_q != 3'h0 |-> hangCnt_q < lrht_pkg::HANG_CNT_W'(HANG_SHORT_CYC);
    endproperty
    a_hang_short: assert property (p_hang_short) else $error("short hang overrun");

    property p_restart;
        @(posedge core_clk) disable iff (sys_rst)
        accept && newOuts != 3'h0 && !zeroPkt |=> hangCnt_q == '0 ##1 hangCnt_q == 1;
    endproperty
    a_restart: assert property (p_restart) else $error("hang count not restarted");

    property p_mode_hold;
        @(posedge core_clk) disable iff (sys_rst) modeTaken_q |=> $stable(mode_q);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed");

    property p_net_drop;
        @(posedge core_clk) disable iff (sys_rst)
        pktValid && netMode && !idBus.hit |=> !fwdValid && $stable(lastId_q);
    endproperty
    a_net_drop: assert property (p_net_drop) else $error("unlearned packet taken");

    property p_open_accept;
        @(posedge core_clk) disable iff (sys_rst)
        pktValid && rxMode && !netMode && pktLen == lrht_pkg::PKT_FULL_LEN |=> fwdValid;
    endproperty
    a_open_accept: assert property (p_open_accept) else $error("packet not accepted");

    property p_learn_enter;
        @(posedge core_clk) disable iff (sys_rst)
        netMode && learnRise |=> learnOut && learnOe;
    endproperty
    a_learn_enter: assert property (p_learn_enter) else $error("learn not entered");

endmodule

// File: lrht_remote_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// remote sender standing in for the radio
// ----------------------------------------
module lrht_remote_model
(
    // clock
    input  wire logic   core_clk,
    // packet towards the receiver
    output logic        pktValid,
    output logic [2:0]  pktLen,
    output logic [39:0] pktData,
    output logic [31:0] pktHdrId
);
    // idle: no packet, payload lines scrambled so stale data never looks valid
    initial
    begin
        pktValid = 1'b0;
        pktLen   = 3'h0;
        pktData  = 40'hA5A5A5A5A5;
        pktHdrId = 32'h5A5A5A5A;
    end

    // one packet: a state byte, then the four identifier bytes when long
    task automatic send(input logic [2:0] len, input logic [7:0] st, input logic [31:0] id);
        @(posedge core_clk);
        pktValid <= 1'b1;
        pktLen   <= len;
        pktData  <= (len == 3'h5) ? {st, id} : {st, 32'h0};
        pktHdrId <= id;
        @(posedge core_clk);
        pktValid <= 1'b0;
        pktData  <= ~pktData;
        pktHdrId <= ~pktHdrId;
    endtask
endmodule

// File: lrht_receiver_bench.sv
`timescale 1ns/1ps
module lrht_receiver_bench;
    // ------------------------------------
    // signals
    // ------------------------------------
    logic        core_clk, sys_rst, learnIn, pktValid, switchOutputA, switchOutputB;
    logic        switchOutputC, radioTxEn, learnOut, learnOe, fwdValid;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic [2:0]  modeSel, pktLen;
    logic [3:0]  s_axi_wstrb;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, b;
    logic [31:0] s_axi_wdata, s_axi_rdata, pktHdrId, rv, id;
    logic [39:0] pktData, fwdData;
    int          error_cnt, total_checks, n;
    wire  [2:0]  sw = {switchOutputC, switchOutputB, switchOutputA};

    lrht_receiver #(.HANG_LONG_CYC(500), .HANG_SHORT_CYC(20)) DUT (.core_clk, .sys_rst,
        .modeSel, .pktValid, .pktLen, .pktData, .pktHdrId, .switchOutputA, .switchOutputB,
        .switchOutputC, .radioTxEn, .learnIn, .learnOut, .learnOe, .fwdValid, .fwdData,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    lrht_remote_model REM (.core_clk, .pktValid, .pktLen, .pktData, .pktHdrId);

    // ------------------------------------
    // helpers
    // ------------------------------------
    task automatic chk(input string s, input logic [39:0] e, input logic [39:0] g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chk_sw(input logic [7:0] v);
        chk("switches", {37'h0, v[6:4]}, {37'h0, sw});
    endtask
    task automatic rst(input logic [2:0] m);
        modeSel <= m;
        sys_rst <= 1'b1;
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask
    // counts cycles until all switches drop; a hold that never ends stops at 2000
    task automatic hang();
        n = 0;
        while (sw !== 3'h0 && n < 2000)
        begin
            @(posedge core_clk);
            #1 n++;
        end
    endtask
    // each channel is released at the edge where its ready is seen high
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic ha, hw;
        @(posedge core_clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
        ha = 1'b0;
        hw = 1'b0;
        while (!(ha && hw))
        begin
            @(posedge core_clk);
            ha = ha | s_axi_awready;
            hw = hw | s_axi_wready;
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
        end
        do @(posedge core_clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge core_clk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do @(posedge core_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (!s_axi_rvalid);
        {rv, rr} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ------------------------------------
    // clock, watchdog, stimulus
    // ------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // generous bound over the roughly one thousand cycles the tests take
    initial
    begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        end_sim();
    end
    initial
    begin
        {sys_rst, learnIn, modeSel, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = {1'b1, 52'h0};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        s_axi_wstrb = 4'hF;
        void'($urandom(32'hc901));
        rst(3'h4);
        chk("txen", 40'h0, {39'h0, radioTxEn});
        for (int i = 0; i < 8; i++)
        begin
            b = {1'b0, i[2:0], 4'($urandom)};
            id = $urandom;
            REM.send((i % 2) ? 3'h5 : 3'h1, b, id);
            #1 chk_sw(b);
            chk("fwd", {b, id}, fwdData);
            chk("fwdv", {39'h0, i % 2 == 1}, {39'h0, fwdValid});
        end
        axr(lrht_pkg::ADDR_LASTID);
        chk("lastid", {8'h0, id}, {8'h0, rv});
        axr(8'hFC);
        chk("resp", {38'h0, lrht_pkg::RESP_DECERR}, {38'h0, rr});
        REM.send(3'h1, 8'h70, 32'h0);
        repeat (300) @(posedge core_clk);
        REM.send(3'h1, 8'h50, 32'h0);
        #1 chk_sw(8'h50);
        hang();
        chk("hang long", 40'd500, 40'(n));
        REM.send(3'h5, 8'h70, 32'h1);
        repeat (5) @(posedge core_clk);
        REM.send(3'h1, 8'h00, 32'h1);
        #1 chk_sw(8'h00);
        REM.send(3'h1, 8'h20, 32'h1);
        axw(lrht_pkg::ADDR_CTRL, 32'h4);
        #1 chk_sw(8'h00);
        rst(3'h6);
        // refresh every 15 cycles keeps a 20-cycle hang from dropping
        for (int i = 0; i < 4; i++)
        begin
            REM.send(3'h1, 8'h10, 32'h0);
            repeat (13) @(posedge core_clk);
            #1 chk_sw(8'h10);
        end
        REM.send(3'h1, {1'b0, 3'($urandom) | 3'h1, 4'h0}, 32'h0);
        #1 hang();
        chk("hang short", 40'd20, 40'(n));
        rst(3'h7);
        id = $urandom;
        REM.send(3'h5, 8'h30, id);
        #1 chk_sw(8'h00);
        chk("fwdv", 40'h0, {39'h0, fwdValid});
        learnIn <= 1'b1;
        repeat (2) @(posedge core_clk);
        learnIn <= 1'b0;
        #1 chk("learn", 40'h3, {38'h0, learnOut, learnOe});
        REM.send(3'h5, 8'h30, id);
        REM.send(3'h5, 8'h30, id);
        #1 chk_sw(8'h30);
        hang();
        chk("hang net", 40'd20, 40'(n));
        axr(lrht_pkg::ADDR_STATUS);
        chk("status", {8'h0, 32'h170}, {8'h0, rv});
        end_sim();
    end
endmodule
